// ===== inc/redriver_cfg_pkg.sv
/*
 * Constants and types for the lane equalizer, swing and enable registers.
 * Assumes byte-wide register accesses handed over by the serial target
 * engine, and a generation code supplied by the rate logic.
 */
package redriver_cfg_pkg;

   // ---------------------------------------------------------------
   // Register offsets and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] equalizer_select_control_off = 8'h0E;
   localparam logic [7:0] lane_swing_and_enables_off = 8'h11;
   localparam logic [7:0] clock_lane_emphasis_swing_off = 8'h12;
   localparam logic [7:0] equalizer_select_control_rst = 8'h3F;
   localparam logic [7:0] lane_swing_and_enables_rst = 8'h5F;
   localparam logic [7:0] clock_lane_emphasis_swing_rst = 8'h03;
   localparam logic [7:0] unmapped_read_value = 8'h00;
   // Writable bits of the clock lane register; bits 7 and 3 reserved
   localparam logic [7:0] clock_lane_write_mask = 8'h77;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int bandwidth_lsb = 6;
   localparam int gen14_select_lsb = 4;
   localparam int gen20_select_lsb = 2;
   localparam int gen21_select_lsb = 0;
   localparam int gen20_preset_lsb = 6;
   localparam int gen14_preset_lsb = 4;
   localparam int clock_lane_on_bit = 3;
   localparam int data0_lane_on_bit = 2;
   localparam int data1_lane_on_bit = 1;
   localparam int data2_lane_on_bit = 0;
   localparam int emphasis_lsb = 4;
   localparam int clock_swing_lsb = 0;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      variant_3g = 2'h0,
      variant_6g = 2'h1,
      variant_auto = 2'h2,
      variant_12g = 2'h3
   } eq_variant_t;

   typedef enum logic [1:0] {
      gen_14 = 2'h0,
      gen_20 = 2'h1,
      gen_21 = 2'h2,
      gen_spare = 2'h3
   } hdmi_gen_t;

   // Swing preset: 0 means per-lane swing fields apply
   localparam logic [1:0] preset_use_lane_fields = 2'h0;
   localparam logic [2:0] emphasis_reserved_code = 3'h3;
   localparam logic [2:0] emphasis_zero_code = 3'h0;
   localparam logic [2:0] linear_swing_last_code = 3'h3;

   // ---------------------------------------------------------------
   // Output bundles
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] bandwidth;
      eq_variant_t clock_variant;
      eq_variant_t data_variant;
   } eq_steer_t;

   typedef struct packed {
      logic [1:0] preset;    // 0 = per-lane fields
      logic gen14_table;     // 1 = 1.4 preset table (3h is -10%)
   } swing_preset_t;

   typedef struct packed {
      logic [2:0] emphasis;  // Effective emphasis code
      logic emphasis_ok;     // Low on reserved emphasis code
      logic [2:0] swing;     // Clock lane swing code
      logic linear;          // Decode swing by linear table
      logic swing_ok;        // Low on reserved linear swing code
   } clock_drive_t;

endpackage

// ===== src/redriver_lane_eq_swing_config_regs.sv
/*
 * Configuration register slice for equalizer selection, swing presets,
 * lane enables and clock lane emphasis and swing.
 * Assumes the serial target engine presents one byte access at a time
 * with a one-cycle strobe, and that the generation, snooped rate and
 * global mode bit arrive synchronous to ref_clk.
 */
`timescale 1ns/100ps

// Function
// R01 - Two-bit equalizer bandwidth, bits 7-6
// R02 - Bits 5-4 pick data variant at 1.4
// R03 - Clock lane uses 3G at 1.4/2.0
// R04 - Bits 3-2 pick data variant at 2.0
// R05 - Bits 1-0 pick all-lane variant at 2.1
// R06 - Select 2h resolves from snooped rate
// R07 - Bits 7-6 pick limited swing at 2.0
// R08 - Bits 5-4 pick limited swing at 1.4
// R09 - Bits 3-0 enable clock, data0-2 lanes
// R10 - Clock emphasis honored only at 2.1
// R11 - Emphasis decode, code 3h reserved
// R12 - Clock swing decoded per redriver mode
// R13 - Mode bit: zero limited, one linear
// R14 - Reserved bits read zero, writes ignored
module redriver_lane_eq_swing_config_regs
   import redriver_cfg_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register access from the serial target engine
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Link state from rate logic and global control
   input wire hdmi_gen_t hdmi_gen,
   input wire eq_variant_t snoop_variant,
   input wire logic linear_mode_select,
   // Analog steering
   output eq_steer_t eq_steer,
   output swing_preset_t swing_preset,
   output logic [3:0] lane_on,
   output clock_drive_t clock_drive
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [7:0] equalizer_select_control;
   logic [7:0] lane_swing_and_enables;
   logic [7:0] clock_lane_emphasis_swing;
   // Next values of the registered outputs
   eq_steer_t next_eq_steer;
   swing_preset_t next_swing_preset;
   clock_drive_t next_clock_drive;
   logic [7:0] next_rdata;

   // Replace an automatic selection with the snooped rate
   function automatic eq_variant_t resolve(input logic [1:0] sel,
                                           input eq_variant_t snooped);
      resolve = eq_variant_t'(sel);
      if (sel == variant_auto)
         resolve = snooped; // R06
   endfunction

   // Equalizer register, all bits writable; a write reaches the
   // steering outputs one edge after it is stored
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         equalizer_select_control <= equalizer_select_control_rst;
      else if (reg_write && reg_addr == equalizer_select_control_off)
         equalizer_select_control <= reg_wdata;
   end

   // Swing preset and lane enable register; all lanes on after reset
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         lane_swing_and_enables <= lane_swing_and_enables_rst; // R09
      else if (reg_write && reg_addr == lane_swing_and_enables_off)
         lane_swing_and_enables <= reg_wdata;
   end

   // Clock lane register; reserved bits are masked so they never store
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         clock_lane_emphasis_swing <= clock_lane_emphasis_swing_rst;
      else if (reg_write && reg_addr == clock_lane_emphasis_swing_off)
         clock_lane_emphasis_swing <= reg_wdata & clock_lane_write_mask; // R14
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   // Read data is captured on the strobe and held until the next read
   always_comb
   begin
      case (reg_addr)
         equalizer_select_control_off:
            next_rdata = equalizer_select_control;
         lane_swing_and_enables_off:
            next_rdata = lane_swing_and_enables;
         clock_lane_emphasis_swing_off:
            next_rdata = clock_lane_emphasis_swing; // R14
         default:
            next_rdata = unmapped_read_value;
      endcase
   end

   // Read data flop; holds between reads so a slow engine can fetch it
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         reg_rdata <= unmapped_read_value;
      else if (reg_read)
         reg_rdata <= next_rdata;
   end

   // ---------------------------------------------------------------
   // Equalizer steering
   // ---------------------------------------------------------------
   // Spare generation code is treated as 1.4 so lanes stay conservative
   always_comb
   begin
      next_eq_steer.bandwidth =
         equalizer_select_control[bandwidth_lsb +: 2]; // R01
      next_eq_steer.clock_variant = variant_3g; // R03
      case (hdmi_gen)
         gen_20:
            next_eq_steer.data_variant = resolve(
               equalizer_select_control[gen20_select_lsb +: 2],
               snoop_variant); // R04
         gen_21:
         begin
            next_eq_steer.data_variant = resolve(
               equalizer_select_control[gen21_select_lsb +: 2],
               snoop_variant); // R05
            next_eq_steer.clock_variant =
               next_eq_steer.data_variant; // R05
         end
         default:
            next_eq_steer.data_variant = resolve(
               equalizer_select_control[gen14_select_lsb +: 2],
               snoop_variant); // R02
      endcase
   end

   // ---------------------------------------------------------------
   // Swing presets
   // ---------------------------------------------------------------
   // Presets exist only for the limited redriver below 2.1; elsewhere
   // the per-lane swing fields always apply
   always_comb
   begin
      next_swing_preset.preset = preset_use_lane_fields;
      next_swing_preset.gen14_table = 1'b0;
      if (!linear_mode_select) // R13
      begin
         case (hdmi_gen)
            gen_20:
               next_swing_preset.preset =
                  lane_swing_and_enables[gen20_preset_lsb +: 2]; // R07
            gen_21:
               next_swing_preset.preset = preset_use_lane_fields;
            default:
            begin
               next_swing_preset.preset =
                  lane_swing_and_enables[gen14_preset_lsb +: 2]; // R08
               next_swing_preset.gen14_table = 1'b1; // R08
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Clock lane drive
   // ---------------------------------------------------------------
   // Reserved codes are flagged rather than altered so the analog side
   // can hold its last safe setting
   always_comb
   begin
      // Zero emphasis outside 2.1 so the clock lane sees no boost
      next_clock_drive.emphasis = emphasis_zero_code;
      if (hdmi_gen == gen_21)
         next_clock_drive.emphasis =
            clock_lane_emphasis_swing[emphasis_lsb +: 3]; // R10
      next_clock_drive.emphasis_ok =
         next_clock_drive.emphasis != emphasis_reserved_code; // R11
      next_clock_drive.swing =
         clock_lane_emphasis_swing[clock_swing_lsb +: 3]; // R12
      next_clock_drive.linear = linear_mode_select; // R13
      next_clock_drive.swing_ok = !linear_mode_select ||
         next_clock_drive.swing <= linear_swing_last_code; // R12
   end

   // Registered outputs; reset clears them, so lanes stay off until the
   // first edge after release loads them from the registers
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         eq_steer <= '0;
         swing_preset <= '0;
         lane_on <= 4'h0;
         clock_drive <= '0;
      end
      else
      begin
         eq_steer <= next_eq_steer;
         swing_preset <= next_swing_preset;
         lane_on <= {lane_swing_and_enables[clock_lane_on_bit],
                     lane_swing_and_enables[data0_lane_on_bit],
                     lane_swing_and_enables[data1_lane_on_bit],
                     lane_swing_and_enables[data2_lane_on_bit]}; // R09
         clock_drive <= next_clock_drive;
      end
   end

endmodule

// ===== tb/redriver_cfg_asserts.sv
/* Port checker for the lane register slice.
   Assumes binding onto the slice's top module. */
`timescale 1ns/100ps
module redriver_cfg_asserts
   import redriver_cfg_pkg::*;
(
   // Clock, reset and byte port
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Link state and steering
   input wire hdmi_gen_t hdmi_gen,
   input wire eq_variant_t snoop_variant,
   input wire logic linear_mode_select,
   input wire eq_steer_t eq_steer,
   input wire swing_preset_t swing_preset,
   input wire logic [3:0] lane_on,
   input wire clock_drive_t clock_drive
);
   // Copy of the equalizer register, kept from the byte port alone
   logic [7:0] eq_shadow;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         eq_shadow <= equalizer_select_control_rst;
      else if (reg_write && reg_addr == equalizer_select_control_off)
         eq_shadow <= reg_wdata;
   end
   // Outputs lag one edge; reset blanks them, so guard two edges
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   lane_write_a: assert property (reg_write && reg_addr == 8'h11 ##1
      !(reg_write && reg_addr == 8'h11) |=> lane_on == $past(reg_wdata[3:0], 2))
      else $error("lane enables wrong");
   clock_fixed_a: assert property (hdmi_gen != gen_21 |=>
      eq_steer.clock_variant == variant_3g) else $error("clock not 3G");
   all_lanes_a: assert property (hdmi_gen == gen_21 |=>
      eq_steer.clock_variant == eq_steer.data_variant) else $error("lanes split");
   auto_pick_a: assert property (hdmi_gen == gen_20 &&
      eq_shadow[gen20_select_lsb +: 2] == variant_auto |=>
      eq_steer.data_variant == $past(snoop_variant))
      else $error("auto unresolved");
   emph_off_a: assert property (hdmi_gen != gen_21 |=>
      clock_drive.emphasis == 3'h0) else $error("emphasis not ignored");
   emph_ok_a: assert property (!$past(reset) && !$past(reset, 2) |->
      clock_drive.emphasis_ok == (clock_drive.emphasis != 3'h3))
      else $error("emphasis flag wrong");
   swing_ok_a: assert property (!$past(reset) && !$past(reset, 2) |->
      clock_drive.swing_ok == (!clock_drive.linear || clock_drive.swing < 3'h4))
      else $error("swing flag wrong");
   unmapped_read_a: assert property (reg_read && !(reg_addr inside
      {8'h0E, 8'h11, 8'h12}) |=> reg_rdata == 8'h00) else $error("unmapped read");
   cover property (hdmi_gen == gen_21 && eq_steer.data_variant == variant_6g);
   cover property (linear_mode_select && !clock_drive.swing_ok);
   cover property (reg_read && reg_addr == 8'h0F);
endmodule

bind redriver_lane_eq_swing_config_regs redriver_cfg_asserts chk_u (.ref_clk,
   .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .hdmi_gen, .snoop_variant, .linear_mode_select, .eq_steer, .swing_preset,
   .lane_on, .clock_drive);

// ===== tb/redriver_lane_eq_swing_config_regs_tb.sv
/* Bench for the equalizer, swing and lane enable registers.
   Assumes reg_host_model drives the byte port. */
`timescale 1ns/100ps
module redriver_lane_eq_swing_config_regs_tb
   import redriver_cfg_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, val;
   logic reg_write, reg_read, linear_mode_select = 1'b0;
   hdmi_gen_t hdmi_gen = gen_14;
   eq_variant_t snoop_variant = variant_6g;
   eq_steer_t eq_steer;
   swing_preset_t swing_preset;
   logic [3:0] lane_on;
   clock_drive_t clock_drive;
   logic [8:0] ex;
   logic [1:0] dv;
   int n_mismatch = 0;
   int checks_done = 0;
   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;
   reg_host_model host_u (.ref_clk, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata);
   redriver_lane_eq_swing_config_regs dut_u (.ref_clk, .reset, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata, .hdmi_gen,
      .snoop_variant, .linear_mode_select, .eq_steer, .swing_preset,
      .lane_on, .clock_drive);
   task automatic chk(input string what, input logic [8:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Outputs are flops, so give link state two edges to arrive
   task automatic apply(input int g, input logic lin);
      @(posedge ref_clk);
      hdmi_gen <= hdmi_gen_t'(g);
      linear_mode_select <= lin;
      snoop_variant <= (g == 1) ? variant_12g : variant_6g;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic t_reset;
      logic [7:0] a [4] = '{8'h0E, 8'h11, 8'h12, 8'h0F};
      logic [7:0] e [4] = '{8'h3F, 8'h5F, 8'h03, 8'h00};
      for (int i = 0; i < 4; i++)
      begin
         host_u.xfer(1'b0, a[i], 8'h00, rd);
         chk("reset read", 9'(rd), 9'(e[i]));
      end
      chk("lane on", 9'(lane_on), 9'h00F);
      chk("steer", 9'(eq_steer), 9'h003);
   endtask
   // Other select fields hold the inverse code, so a wrong field shows
   task automatic t_eq;
      for (int g = 0; g < 3; g++)
         for (int v = 0; v < 4; v++)
         begin
            val = {v[1:0], ~v[1:0], ~v[1:0], ~v[1:0]};
            val[5 - 2 * g -: 2] = v[1:0];
            host_u.xfer(1'b1, 8'h0E, val, rd);
            apply(g, 1'b0);
            dv = (v == 2) ? snoop_variant : v[1:0];
            ex = {3'h0, v[1:0], ((g == 2) ? dv : 2'h0), dv};
            chk("steer", 9'(eq_steer), ex);
         end
   endtask
   task automatic t_lane;
      logic [7:0] l [3] = '{8'h9A, 8'h65, 8'hF0};
      for (int i = 0; i < 3; i++)
      begin
         host_u.xfer(1'b1, 8'h11, l[i], rd);
         apply(1, 1'b0);
         chk("p20", 9'(swing_preset), 9'({l[i][7:6], 1'b0}));
         apply(0, 1'b0);
         chk("p14", 9'(swing_preset), 9'({l[i][5:4], 1'b1}));
         chk("lanes", 9'(lane_on), 9'(l[i][3:0]));
         apply(2, 1'b0);
         chk("p21", 9'(swing_preset), 9'h000);
         apply(3, 1'b0);
         chk("pspare", 9'(swing_preset), 9'({l[i][5:4], 1'b1}));
         apply(0, 1'b1);
         chk("linear", 9'(swing_preset), 9'h000);
      end
   endtask
   task automatic t_clk;
      host_u.xfer(1'b1, 8'h12, 8'hFF, rd);
      host_u.xfer(1'b0, 8'h12, 8'h00, rd);
      chk("clk reg", 9'(rd), 9'h077);
      for (int e = 0; e < 8; e++)
      begin
         host_u.xfer(1'b1, 8'h12, {1'b0, e[2:0], 1'b0, e[2:0]}, rd);
         apply(2, e[0]);
         ex = {e[2:0], e != 3, e[2:0], e[0], !e[0] || e < 4};
         chk("drive21", 9'(clock_drive), ex);
         apply(0, e[0]);
         ex[8:5] = 4'h1;
         chk("drive14", 9'(clock_drive), ex);
      end
   endtask
   // Mid-run reset must bring back reset values with all lanes on
   task automatic t_rerst;
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
   endtask
   task automatic finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Reset for 12 cycles, then the scenarios
   initial
   begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_eq();
      t_lane();
      t_clk();
      t_rerst();
      finish_test();
   end
   // Watchdog: the scenarios need well under 1000 cycles
   initial
   begin
      #100000;
      n_mismatch++;
      finish_test();
   end
endmodule

// ===== tb/reg_host_model.sv
/* Host model for the byte register port.
   Assumes a free-running ref_clk and one access at a time. */
`timescale 1ns/100ps
module reg_host_model
(
   // Clock
   input wire logic ref_clk,
   // Byte access port
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   output logic reg_write = 1'b0,
   output logic reg_read = 1'b0,
   input wire logic [7:0] reg_rdata
);
   // One access; the strobe stands across exactly one edge
   task automatic xfer(input logic wr, input logic [7:0] a, d,
      output logic [7:0] q);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= wr;
      reg_read <= !wr;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      reg_wdata <= ~d; // Stale data flipped so nothing leans on it
      #1;
      q = reg_rdata;
   endtask
endmodule
